// [design/aotb_bank.sv]
// offset correction trim bank for converter cores a and b
// assumes a register master that keeps to one-cycle strobes, fuse trim
// values that are stable while reset is low, and synchronous conditions
`timescale 1ns/1ps

module aotb_bank #(
  parameter int DATA_W = 16,
  parameter int FIELD_W = 12
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // register port
  input wire logic [aotb_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // fuse trim defaults, one field per register
  input wire logic [aotb_pkg::NUM_REGS-1:0][FIELD_W-1:0] fuse_trim_in,
  // operating conditions
  input wire aotb_pkg::aotb_cond_t cond_in,
  // corrections to the cores
  output aotb_pkg::aotb_corr_t core_a_corr_out,
  output aotb_pkg::aotb_corr_t core_b_corr_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != aotb_pkg::DATA_W) begin : g_chk_data
    $error("data width must match the register layout");
  end
  if (FIELD_W != aotb_pkg::FIELD_W) begin : g_chk_field
    $error("field width must match the register layout");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // maps an address to a bank index; hit is low for unmapped addresses
  function automatic logic [aotb_pkg::IDX_W:0] decode(
    input logic [aotb_pkg::ADDR_W-1:0] addr
  );
    logic [aotb_pkg::IDX_W:0] res;
    res = '0;
    unique case (addr)
      aotb_pkg::CORE_A_DUAL_INPUT_A_OFFSET_ADDR: res = {1'b1, aotb_pkg::IDX_A_DUAL_INA};
      aotb_pkg::CORE_A_DUAL_INPUT_B_OFFSET_ADDR: res = {1'b1, aotb_pkg::IDX_A_DUAL_INB};
      aotb_pkg::CORE_A_SINGLE_INPUT_A_OFFSET_ADDR: res = {1'b1, aotb_pkg::IDX_A_SINGLE_INA};
      aotb_pkg::CORE_A_SINGLE_INPUT_B_OFFSET_ADDR: res = {1'b1, aotb_pkg::IDX_A_SINGLE_INB};
      aotb_pkg::CORE_B_INPUT_A_OFFSET_ADDR: res = {1'b1, aotb_pkg::IDX_B_INA};
      aotb_pkg::CORE_B_INPUT_B_OFFSET_ADDR: res = {1'b1, aotb_pkg::IDX_B_INB};
      default: res = '0;
    endcase
    return res;
  endfunction

  logic [aotb_pkg::IDX_W:0] dec;
  logic hit;
  logic [aotb_pkg::IDX_W-1:0] idx;

  assign dec = decode(reg_addr_in);
  assign hit = dec[aotb_pkg::IDX_W];
  assign idx = dec[aotb_pkg::IDX_W-1:0];

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [aotb_pkg::NUM_REGS-1:0][DATA_W-1:0] regs_r;
  logic [aotb_pkg::NUM_REGS-1:0][DATA_W-1:0] regs_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    regs_nxt = regs_r;
    rdata_nxt = aotb_pkg::RD_IDLE;
    if (!rst_b_in) begin
      for (int i = 0; i < aotb_pkg::NUM_REGS; i++) begin
        regs_nxt[i] = {aotb_pkg::RSVD_RESET, fuse_trim_in[i]};
      end
    end else if (ce_in) begin
      if (reg_wr_in && hit) begin
        regs_nxt[idx] = reg_wdata_in;
      end
      if (reg_rd_in && hit) begin
        rdata_nxt = regs_r[idx];
      end
    end else begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    regs_r <= regs_nxt;
    rdata_r <= rdata_nxt;
  end

  assign reg_rdata_out = rdata_r;

  // ----------------------------------------------------------------
  // correction select
  // ----------------------------------------------------------------
  aotb_pkg::aotb_corr_t corr_a_r;
  aotb_pkg::aotb_corr_t corr_a_nxt;
  aotb_pkg::aotb_corr_t corr_b_r;
  aotb_pkg::aotb_corr_t corr_b_nxt;
  logic [aotb_pkg::IDX_W-1:0] sel_a;
  logic [aotb_pkg::IDX_W-1:0] sel_b;
  logic use_90;

  always_comb begin
    // the 90 degree phase only steers input b; input a follows the channel mode
    use_90 = !cond_in.dual_mode || cond_in.core_a_phase90;
    if (cond_in.core_a_input_b) begin
      sel_a = use_90 ? aotb_pkg::IDX_A_SINGLE_INB
                     : aotb_pkg::IDX_A_DUAL_INB;
    end else begin
      sel_a = cond_in.dual_mode ? aotb_pkg::IDX_A_DUAL_INA
                                : aotb_pkg::IDX_A_SINGLE_INA;
    end
    sel_b = cond_in.core_b_input_b ? aotb_pkg::IDX_B_INB
                                   : aotb_pkg::IDX_B_INA;
    corr_a_nxt = corr_a_r;
    corr_b_nxt = corr_b_r;
    if (!rst_b_in) begin
      corr_a_nxt = '0;
      corr_b_nxt = '0;
    end else if (ce_in) begin
      corr_a_nxt.apply = cond_in.fg_cal_en;
      corr_b_nxt.apply = cond_in.fg_cal_en;
      // reserved bits are dropped here
      corr_a_nxt.value = cond_in.fg_cal_en
        ? regs_r[sel_a][aotb_pkg::OFFSET_MSB:aotb_pkg::OFFSET_LSB]
        : aotb_pkg::OFFSET_OFF;
      corr_b_nxt.value = cond_in.fg_cal_en
        ? regs_r[sel_b][aotb_pkg::OFFSET_MSB:aotb_pkg::OFFSET_LSB]
        : aotb_pkg::OFFSET_OFF;
    end
  end

  always_ff @(posedge core_clk_in) begin
    corr_a_r <= corr_a_nxt;
    corr_b_r <= corr_b_nxt;
  end

  assign core_a_corr_out = corr_a_r;
  assign core_b_corr_out = corr_b_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking

  property p_a_dual_ina;
    disable iff (!rst_b_in)
    ce_in && cond_in.fg_cal_en && cond_in.dual_mode && !cond_in.core_a_input_b
    |=> core_a_corr_out.apply
      && core_a_corr_out.value == $past(regs_r[aotb_pkg::IDX_A_DUAL_INA][11:0]);
  endproperty
  a_a_dual_ina: assert property (p_a_dual_ina)
    else $error("core a dual input a offset not applied");

  property p_a_dual_inb;
    disable iff (!rst_b_in)
    ce_in && cond_in.fg_cal_en && cond_in.dual_mode && !cond_in.core_a_phase90
      && cond_in.core_a_input_b
    |=> core_a_corr_out.value == $past(regs_r[aotb_pkg::IDX_A_DUAL_INB][11:0]);
  endproperty
  a_a_dual_inb: assert property (p_a_dual_inb)
    else $error("core a dual input b offset not applied");

  property p_a_single_ina;
    disable iff (!rst_b_in)
    ce_in && cond_in.fg_cal_en && !cond_in.dual_mode && !cond_in.core_a_input_b
    |=> core_a_corr_out.value == $past(regs_r[aotb_pkg::IDX_A_SINGLE_INA][11:0]);
  endproperty
  a_a_single_ina: assert property (p_a_single_ina)
    else $error("core a single input a offset not applied");

  property p_a_ph90_inb;
    disable iff (!rst_b_in)
    ce_in && cond_in.fg_cal_en && cond_in.core_a_input_b
      && (cond_in.core_a_phase90 || !cond_in.dual_mode)
    |=> core_a_corr_out.value == $past(regs_r[aotb_pkg::IDX_A_SINGLE_INB][11:0]);
  endproperty
  a_a_ph90_inb: assert property (p_a_ph90_inb)
    else $error("core a 90 degree input b offset not applied");

  property p_b_ina;
    disable iff (!rst_b_in)
    ce_in && cond_in.fg_cal_en && !cond_in.core_b_input_b
    |=> core_b_corr_out.apply
      && core_b_corr_out.value == $past(regs_r[aotb_pkg::IDX_B_INA][11:0]);
  endproperty
  a_b_ina: assert property (p_b_ina)
    else $error("core b input a offset not applied");

  property p_b_inb;
    disable iff (!rst_b_in)
    ce_in && cond_in.fg_cal_en && cond_in.core_b_input_b
    |=> core_b_corr_out.value == $past(regs_r[aotb_pkg::IDX_B_INB][11:0]);
  endproperty
  a_b_inb: assert property (p_b_inb)
    else $error("core b input b offset not applied");

  property p_fuse_load;
    !rst_b_in ##1 rst_b_in && ce_in && reg_rd_in
      && reg_addr_in == aotb_pkg::CORE_B_INPUT_B_OFFSET_ADDR
    |=> reg_rdata_out == {4'h0, $past(fuse_trim_in[aotb_pkg::IDX_B_INB], 2)};
  endproperty
  a_fuse_load: assert property (p_fuse_load)
    else $error("fuse trim not loaded at reset");

  property p_write_read;
    disable iff (!rst_b_in)
    ce_in && reg_wr_in && hit ##1 ce_in && reg_rd_in && $past(reg_addr_in) == reg_addr_in
    |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("written value not read back");

  property p_rsvd_reset;
    !rst_b_in |=> regs_r[aotb_pkg::IDX_A_DUAL_INA][15:12] == 4'h0
      && regs_r[aotb_pkg::IDX_B_INB][15:12] == 4'h0;
  endproperty
  a_rsvd_reset: assert property (p_rsvd_reset)
    else $error("reserved bits not cleared at reset");

  property p_cal_off;
    disable iff (!rst_b_in)
    ce_in && !cond_in.fg_cal_en ##1 !ce_in [*2]
    |-> !core_a_corr_out.apply && !core_b_corr_out.apply
      && core_a_corr_out.value == 12'h000 && core_b_corr_out.value == 12'h000;
  endproperty
  a_cal_off: assert property (p_cal_off)
    else $error("correction applied while calibration off");

  property p_unmapped;
    disable iff (!rst_b_in)
    ce_in && reg_rd_in && !hit |=> reg_rdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_ce_freeze;
    disable iff (!rst_b_in)
    !ce_in |=> $stable(reg_rdata_out) && $stable(core_a_corr_out)
      && $stable(core_b_corr_out);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("outputs moved while clock enable low");

  property p_write_lands;
    disable iff (!rst_b_in)
    ce_in && reg_wr_in && hit
    |=> regs_r[$past(idx)] == $past(reg_wdata_in);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write did not reach the register");

  property p_cal_apply;
    disable iff (!rst_b_in)
    ce_in |=> core_a_corr_out.apply == $past(cond_in.fg_cal_en)
      && core_b_corr_out.apply == $past(cond_in.fg_cal_en);
  endproperty
  a_cal_apply: assert property (p_cal_apply)
    else $error("apply flag does not follow calibration enable");

  property p_cal_zero;
    disable iff (!rst_b_in)
    ce_in && !cond_in.fg_cal_en
    |=> core_a_corr_out.value == 12'h000 && core_b_corr_out.value == 12'h000;
  endproperty
  a_cal_zero: assert property (p_cal_zero)
    else $error("correction value not cleared while calibration off");

  property p_rd_idle;
    disable iff (!rst_b_in)
    ce_in && !reg_rd_in |=> reg_rdata_out == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle after a cycle without read");

  property p_reset_out;
    !rst_b_in |=> reg_rdata_out == 16'h0000 && !core_a_corr_out.apply
      && !core_b_corr_out.apply;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not cleared by reset");

endmodule

// [design/aotb_pkg.sv]
// package for the offset trim bank: register map, field layout, carriers
// assumes one 50 mhz clock domain and a plain 16-bit register port
package aotb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 12;
  localparam int NUM_REGS = 6;
  localparam int IDX_W = 3;

  localparam logic [ADDR_W-1:0] CORE_A_DUAL_INPUT_A_OFFSET_ADDR = 12'h344;
  localparam logic [ADDR_W-1:0] CORE_A_DUAL_INPUT_B_OFFSET_ADDR = 12'h346;
  localparam logic [ADDR_W-1:0] CORE_A_SINGLE_INPUT_A_OFFSET_ADDR = 12'h348;
  localparam logic [ADDR_W-1:0] CORE_A_SINGLE_INPUT_B_OFFSET_ADDR = 12'h34a;
  localparam logic [ADDR_W-1:0] CORE_B_INPUT_A_OFFSET_ADDR = 12'h34c;
  localparam logic [ADDR_W-1:0] CORE_B_INPUT_B_OFFSET_ADDR = 12'h34e;

  // register indices inside the bank
  localparam logic [IDX_W-1:0] IDX_A_DUAL_INA = 3'h0;
  localparam logic [IDX_W-1:0] IDX_A_DUAL_INB = 3'h1;
  localparam logic [IDX_W-1:0] IDX_A_SINGLE_INA = 3'h2;
  localparam logic [IDX_W-1:0] IDX_A_SINGLE_INB = 3'h3;
  localparam logic [IDX_W-1:0] IDX_B_INA = 3'h4;
  localparam logic [IDX_W-1:0] IDX_B_INB = 3'h5;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int OFFSET_LSB = 0;
  localparam int OFFSET_MSB = 11;
  localparam int RSVD_LSB = 12;
  localparam int RSVD_MSB = 15;
  localparam logic [RSVD_MSB-RSVD_LSB:0] RSVD_RESET = 4'h0;
  localparam logic [FIELD_W-1:0] OFFSET_OFF = 12'h000;
  localparam logic [DATA_W-1:0] RD_IDLE = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // operating conditions of the converter cores
  typedef struct packed {
    logic fg_cal_en;
    logic dual_mode;
    logic core_a_input_b;
    logic core_a_phase90;
    logic core_b_input_b;
  } aotb_cond_t;

  // correction handed to one core
  typedef struct packed {
    logic apply;
    logic [FIELD_W-1:0] value;
  } aotb_corr_t;

endpackage

// [verif/aotb_bank_bench.sv]
// self-checking bench for the offset trim bank: reference model beside the design
// assumes the bank and package from design/, one 50 mhz clock, synchronous reset
`timescale 1ns/1ps

module aotb_bank_bench;
  localparam int TMO = 20000;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [5:0][11:0] fuse_trim_in = '0;
  aotb_pkg::aotb_cond_t cond_in = '0;
  logic [15:0] reg_rdata_out;
  aotb_pkg::aotb_corr_t core_a_corr_out;
  aotb_pkg::aotb_corr_t core_b_corr_out;
  logic [15:0] m_reg [6];
  logic [15:0] m_rd;
  aotb_pkg::aotb_corr_t m_a;
  aotb_pkg::aotb_corr_t m_b;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int ia;
  int ib;
  int ix;

  aotb_bank u_aotb_bank (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .fuse_trim_in(fuse_trim_in),
    .cond_in(cond_in),
    .core_a_corr_out(core_a_corr_out),
    .core_b_corr_out(core_b_corr_out)
  );

  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  function automatic int idx_of(input logic [11:0] a);
    if (a >= 12'h344 && a <= 12'h34e && !a[0]) return int'((a - 12'h344) >> 1);
    return -1;
  endfunction

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc > TMO) begin
      bad_count++;
      give_verdict();
    end
    ia = cond_in.dual_mode ? 0 : 2;
    if (cond_in.core_a_input_b) ia = (!cond_in.dual_mode || cond_in.core_a_phase90) ? 3 : 1;
    ib = cond_in.core_b_input_b ? 5 : 4;
    ix = idx_of(reg_addr_in);
    if (!rst_b_in) begin
      for (int i = 0; i < 6; i++) m_reg[i] = {4'h0, fuse_trim_in[i]};
      m_rd = 16'h0000;
      m_a = '0;
      m_b = '0;
    end else if (ce_in) begin
      m_a = cond_in.fg_cal_en ? {1'b1, m_reg[ia][11:0]} : '0;
      m_b = cond_in.fg_cal_en ? {1'b1, m_reg[ib][11:0]} : '0;
      m_rd = (reg_rd_in && ix >= 0) ? m_reg[ix] : 16'h0000;
      if (reg_wr_in && ix >= 0) m_reg[ix] = reg_wdata_in;
    end
  end

  // ------------------------------------------------------------
  // comparison at every settled result
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(negedge core_clk_in) begin
    if (cyc > 0) begin
      chk(reg_rdata_out, m_rd, "read data");
      chk({3'h0, core_a_corr_out}, {3'h0, m_a}, "core a correction");
      chk({3'h0, core_b_corr_out}, {3'h0, m_b}, "core b correction");
    end
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task automatic do_reset();
    @(posedge core_clk_in);
    fuse_trim_in <= 72'({$urandom, $urandom, $urandom});
    rst_b_in <= 1'b0;
    ce_in <= 1'b0;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    // first read lands in the cycle right after release
    ce_in <= 1'b1;
    reg_rd_in <= 1'b1;
    reg_addr_in <= 12'h34e;
  endtask

  task automatic op(input logic wr, input logic rd, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= wr;
    reg_rd_in <= rd;
    reg_addr_in <= a;
    reg_wdata_in <= d;
  endtask

  task automatic rand_cycles(input int n);
    int a;
    int k;
    for (int i = 0; i < n; i++) begin
      a = $urandom_range(0, 7);
      k = $urandom_range(0, 2);
      op(k == 1, k == 2, (a < 6) ? 12'h344 + 12'(2 * a) : ((a == 6) ? 12'h345 : 12'h350),
         16'($urandom));
      ce_in <= ($urandom_range(0, 9) != 0);
      cond_in <= 5'($urandom);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h6bc4));
    do_reset();
    // fuse defaults read back, then reserved bits written and read
    cond_in <= 5'h10;
    for (int i = 0; i < 6; i++) op(1'b0, 1'b1, 12'h344 + 12'(2 * i), 16'h0000);
    op(1'b1, 1'b0, 12'h344, 16'hfabc);
    op(1'b0, 1'b1, 12'h344, 16'h0000);
    op(1'b0, 1'b0, 12'h344, 16'h0000);
    rand_cycles(4000);
    do_reset();
    rand_cycles(4000);
    op(1'b0, 1'b0, 12'h000, 16'h0000);
    repeat (2) @(posedge core_clk_in);
    give_verdict();
  end
endmodule
